//--- hw/pcss_map.vh
/*
  Constants of the program counter and stack sequencer: widths, phase
  codes, vectors, stack depth and reset values.
  Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef PCSS_MAP_VH
`define PCSS_MAP_VH

// ****************************************************************
// Widths
// ****************************************************************
`define PCSS_PC_W        14
`define PCSS_LOW_W       13
`define PCSS_INSTR_W     16
`define PCSS_IRQ_N       6
`define PCSS_SP_W        4
`define PCSS_IDX_W       3
`define PCSS_PCL_W       8

// ****************************************************************
// Phases, one-hot: first to fourth
// ****************************************************************
`define PCSS_PH_FIRST    4'h1
`define PCSS_PH_SECOND   4'h2
`define PCSS_PH_THIRD    4'h4
`define PCSS_PH_FOURTH   4'h8
`define PCSS_PH_LAST_BIT 3

// ****************************************************************
// Program counter values and steps
// ****************************************************************
`define PCSS_VEC_RESET   14'h0000
`define PCSS_VEC_EXT     14'h0004
`define PCSS_VEC_TMR0    14'h0008
`define PCSS_VEC_TMR1    14'h000c
`define PCSS_VEC_TONE    14'h0010
`define PCSS_VEC_RTC     14'h0014
`define PCSS_VEC_MULTI   14'h0018
`define PCSS_PC_STEP     13'h0001
`define PCSS_BANK_BIT    13

// ****************************************************************
// Stack
// ****************************************************************
`define PCSS_SP_EMPTY    4'h0
`define PCSS_SP_FULL     4'h8
`define PCSS_SP_STEP     4'h1
`define PCSS_IDX_STEP    3'h1
`define PCSS_IDX_RESET   3'h0
`define PCSS_STACK_DEPTH 8

`define PCSS_INSTR_RESET 16'h0000
`define PCSS_PCL_RESET   8'h00
`define PCSS_IRQ_NONE    6'h00

`endif

//--- hw/pcss_stack_ram.v
/*
  Eight-entry return address memory of the sequencer, one write port and
  one read port whose data come out of a register.
  Assumes one clock; read data lag the read address by one edge.
*/
`timescale 1ns/1ns
`include "pcss_map.vh"

module pcss_stack_ram (
  input  wire                      clk_sys,
  input  wire                      wr_en,
  input  wire [`PCSS_IDX_W-1:0]    wr_idx,
  input  wire [`PCSS_PC_W-1:0]     wr_data,
  input  wire [`PCSS_IDX_W-1:0]    rd_idx,
  output reg  [`PCSS_PC_W-1:0]     rd_data_q
);

  reg [`PCSS_PC_W-1:0] mem [0:`PCSS_STACK_DEPTH-1];

  // Contents carry no reset: an empty stack is marked by the level
  // pointer alone, and a return on an empty stack still loads the stale word below the index.
  always @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data_q <= mem[rd_idx];
  end

endmodule // pcss_stack_ram

//--- hw/pcss_seq.v
/*
  Instruction sequencer: four-phase instruction cycle, fetch/execute
  overlap, 14-bit program counter with writable low byte, dummy cycles,
  eight-level return stack and interrupt vectoring.
  Assumes program memory answers prog_addr by the fourth phase, and the
  execute unit presents its decoded controls during the fourth phase,
  all on clk_sys. Interrupt requests are pulses from logic on clk_sys.
*/
`timescale 1ns/1ns
`include "pcss_map.vh"

module pcss_seq (
  input  wire                      clk_sys,
  input  wire                      sys_rst,
  input  wire [`PCSS_INSTR_W-1:0]  prog_data,
  input  wire                      unconditional_jump,
  input  wire                      call_op,
  input  wire                      subroutine_exit,
  input  wire                      isr_exit,
  input  wire                      skip_taken,
  input  wire                      pcl_write,
  input  wire [7:0]                pcl_wdata,
  input  wire [`PCSS_LOW_W-1:0]    addr_field,
  input  wire                      bank_pointer_bit5,
  input  wire                      int_enable,
  input  wire [`PCSS_IRQ_N-1:0]    irq_req,
  output reg  [3:0]                phase_q,
  output reg  [`PCSS_PC_W-1:0]     prog_addr_q,
  output reg  [7:0]                program_counter_low_q,
  output reg  [`PCSS_INSTR_W-1:0]  exec_instr_q,
  output reg                       exec_valid_q,
  output reg  [`PCSS_IRQ_N-1:0]    irq_pend_q,
  output reg  [`PCSS_IRQ_N-1:0]    irq_ack_q,
  output reg                       stack_full_q
);

  // ****************************************************************
  // Internal state
  // ****************************************************************
  reg  [`PCSS_PC_W-1:0]    pc_q;
  reg  [`PCSS_PC_W-1:0]    pc_d;
  reg  [`PCSS_SP_W-1:0]    stack_level_pointer_q;
  reg  [`PCSS_SP_W-1:0]    stack_level_pointer_d;
  reg  [`PCSS_IDX_W-1:0]   idx_q;
  reg  [`PCSS_IDX_W-1:0]   idx_d;
  reg  [`PCSS_PC_W-1:0]    vector_sel;
  reg                      exec_valid_d;
  reg  [`PCSS_IRQ_N-1:0]   irq_ack_d;
  wire [`PCSS_PC_W-1:0]    pop_data;
  wire [`PCSS_PC_W-1:0]    pc_inc;
  wire [`PCSS_IDX_W-1:0]   top_idx;
  wire [`PCSS_IRQ_N-1:0]   grant;
  wire [`PCSS_IRQ_N:0]     lower_busy;
  wire                     cycle_end;
  wire                     do_jump;
  wire                     do_call;
  wire                     do_pop;
  wire                     do_pcl;
  wire                     do_skip;
  wire                     full_now;
  wire                     do_irq;
  wire                     do_push;
  wire                     discard;

  // ****************************************************************
  // Phase generator
  // ****************************************************************
  // One phase per clock; the edge after the fourth phase starts the
  // next instruction cycle.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      phase_q <= `PCSS_PH_FIRST;
    end else begin
      case (phase_q)
        `PCSS_PH_FIRST: begin
          phase_q <= `PCSS_PH_SECOND;
        end
        `PCSS_PH_SECOND: begin
          phase_q <= `PCSS_PH_THIRD;
        end
        `PCSS_PH_THIRD: begin
          phase_q <= `PCSS_PH_FOURTH;
        end
        `PCSS_PH_FOURTH: begin
          phase_q <= `PCSS_PH_FIRST;
        end
        default: begin
          phase_q <= `PCSS_PH_FIRST;
        end
      endcase
    end
  end

  assign cycle_end = phase_q[`PCSS_PH_LAST_BIT];

  // ****************************************************************
  // Decoded controls of the executing instruction
  // ****************************************************************
  // A dummy cycle executes nothing, so its controls are ignored.
  assign do_jump = exec_valid_q & unconditional_jump;
  assign do_call = exec_valid_q & call_op;
  assign do_pop  = exec_valid_q & (subroutine_exit | isr_exit);
  assign do_pcl  = exec_valid_q & pcl_write;
  assign do_skip = exec_valid_q & skip_taken;

  // ****************************************************************
  // Interrupt pending flags and priority
  // ****************************************************************
  // Lowest index wins; the lower_busy chain masks the rest.
  assign lower_busy[0] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < `PCSS_IRQ_N; gi = gi + 1) begin : g_irq
      assign grant[gi]        = irq_pend_q[gi] & ~lower_busy[gi];
      assign lower_busy[gi+1] = lower_busy[gi] | irq_pend_q[gi];

      // A new request in the acknowledge cycle stays pending.
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          irq_pend_q[gi] <= 1'b0;
        end else if (irq_req[gi]) begin
          irq_pend_q[gi] <= 1'b1;
        end else if (do_irq && grant[gi]) begin
          irq_pend_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @* begin
    case (grant)
      6'h01: begin
        vector_sel = `PCSS_VEC_EXT;
      end
      6'h02: begin
        vector_sel = `PCSS_VEC_TMR0;
      end
      6'h04: begin
        vector_sel = `PCSS_VEC_TMR1;
      end
      6'h08: begin
        vector_sel = `PCSS_VEC_TONE;
      end
      6'h10: begin
        vector_sel = `PCSS_VEC_RTC;
      end
      6'h20: begin
        vector_sel = `PCSS_VEC_MULTI;
      end
      // No grant means no acknowledge, so this value is never loaded.
      default: begin
        vector_sel = `PCSS_VEC_RESET;
      end
    endcase
  end

  // A full stack holds off the acknowledge, and so does an executing
  // branch, skip or return; the request is taken at a later boundary.
  assign full_now = (stack_level_pointer_q == `PCSS_SP_FULL);
  // Taken only at the cycle boundary, so the flag clears on the very
  // edge that loads the vector and a request is never dropped early.
  assign do_irq   = cycle_end & int_enable & (|irq_pend_q) & ~full_now
                  & ~(do_jump | do_call | do_pop | do_pcl | do_skip);

  // ****************************************************************
  // Program counter
  // ****************************************************************
  // pc_q is the address being fetched. Stepping keeps the bank bit.
  assign pc_inc = {pc_q[`PCSS_BANK_BIT], pc_q[`PCSS_LOW_W-1:0] + `PCSS_PC_STEP};

  always @* begin
    pc_d = pc_q;
    if (cycle_end) begin
      if (do_jump || do_call) begin
        pc_d = {bank_pointer_bit5, addr_field};
      end else if (do_pop) begin
        pc_d = pop_data;
      end else if (do_pcl) begin
        pc_d = {pc_q[`PCSS_PC_W-1:`PCSS_PCL_W], pcl_wdata};
      end else if (do_irq) begin
        pc_d = vector_sel;
      end else begin
        // A taken skip also just steps: the fetched word is dropped.
        pc_d = pc_inc;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pc_q                  <= `PCSS_VEC_RESET;
      prog_addr_q           <= `PCSS_VEC_RESET;
      program_counter_low_q <= `PCSS_PCL_RESET;
    end else if (cycle_end) begin
      // The counter changes on the edge that opens the first phase.
      pc_q                  <= pc_d;
      prog_addr_q           <= pc_d;
      program_counter_low_q <= pc_d[`PCSS_PCL_W-1:0];
    end
  end

  // ****************************************************************
  // Execute stage
  // ****************************************************************
  // Every redirect drops the word fetched in this cycle, which turns
  // the next cycle into a dummy: two cycles per branch.
  assign discard = do_jump | do_call | do_pop | do_pcl | do_skip | do_irq;

  always @* begin
    exec_valid_d = exec_valid_q;
    irq_ack_d    = `PCSS_IRQ_NONE;
    if (cycle_end) begin
      exec_valid_d = ~discard;
      if (do_skip) begin
        // The prefetched word behind a taken skip is thrown away.
        exec_valid_d = 1'b0;
      end
      if (do_irq) begin
        irq_ack_d = grant;
      end
    end
  end

  // The executed word is taken on the same edge as the new address.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      exec_instr_q <= `PCSS_INSTR_RESET;
      exec_valid_q <= 1'b0;
      irq_ack_q    <= `PCSS_IRQ_NONE;
    end else begin
      exec_valid_q <= exec_valid_d;
      irq_ack_q    <= irq_ack_d;
      if (cycle_end) begin
        exec_instr_q <= prog_data;
      end
    end
  end

  // ****************************************************************
  // Return stack
  // ****************************************************************
  // The push saves pc_q, the address of the word being discarded, so
  // the return resumes exactly there.
  assign do_push = cycle_end & (do_call | do_irq);
  assign top_idx = idx_q - `PCSS_IDX_STEP;

  always @* begin
    idx_d                 = idx_q;
    stack_level_pointer_d = stack_level_pointer_q;
    if (do_push) begin
      // Overflow wraps the index and overwrites the oldest entry.
      idx_d = idx_q + `PCSS_IDX_STEP;
      if (!full_now) begin
        stack_level_pointer_d = stack_level_pointer_q + `PCSS_SP_STEP;
      end
    end else if (cycle_end && do_pop) begin
      idx_d = top_idx;
      if (stack_level_pointer_q != `PCSS_SP_EMPTY) begin
        stack_level_pointer_d = stack_level_pointer_q - `PCSS_SP_STEP;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      idx_q                 <= `PCSS_IDX_RESET;
      stack_level_pointer_q <= `PCSS_SP_EMPTY;
      stack_full_q          <= 1'b0;
    end else begin
      idx_q                 <= idx_d;
      stack_level_pointer_q <= stack_level_pointer_d;
      stack_full_q          <= (stack_level_pointer_d == `PCSS_SP_FULL);
    end
  end

  // The read index is steady through the cycle, so the registered
  // read data are settled long before the fourth phase.
  pcss_stack_ram u_stack (
    .clk_sys   (clk_sys),
    .wr_en     (do_push),
    .wr_idx    (idx_q),
    .wr_data   (pc_q),
    .rd_idx    (top_idx),
    .rd_data_q (pop_data)
  );

endmodule // pcss_seq

//--- bench/pcss_seq_assertions.sv
/* Checker bound to pcss_seq: phase order, fetch address after jumps, calls, skips, low byte writes and vectors,
   dummy cycles, interrupt acknowledge and reset state.
   Assumes every port of the sequencer lives on clk_sys. */
`timescale 1ns/1ns
module pcss_seq_chk (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire [12:0] addr_field,
  input wire        bank_pointer_bit5,
  input wire        unconditional_jump,
  input wire        call_op,
  input wire        subroutine_exit,
  input wire        isr_exit,
  input wire        skip_taken,
  input wire        pcl_write,
  input wire [7:0]  pcl_wdata,
  input wire [5:0]  irq_req,
  input wire [3:0]  phase_q,
  input wire [13:0] prog_addr_q,
  input wire        exec_valid_q,
  input wire [5:0]  irq_pend_q,
  input wire [5:0]  irq_ack_q,
  input wire        stack_full_q
);
  wire        jc = unconditional_jump | call_op;
  wire        rt = subroutine_exit | isr_exit;
  // Plain cycle only when no request could be taken at the same edge
  wire        plain = !jc && !rt && !skip_taken && !pcl_write && (irq_pend_q | irq_req) == 6'h00;
  wire [13:0] inc = {prog_addr_q[13], prog_addr_q[12:0] + 13'h0001};
  wire [13:0] pg = {prog_addr_q[13:8], pcl_wdata};
  wire [13:0] vec = {9'h000, |irq_ack_q[5:3], irq_ack_q[5] | irq_ack_q[2] | irq_ack_q[1],
                     irq_ack_q[4] | irq_ack_q[2] | irq_ack_q[0], 2'h0};
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence real_end; phase_q == 4'h8 && exec_valid_q; endsequence
  sequence dummy_run; !exec_valid_q [*4]; endsequence

  a_phase_order: assert property (1'b1 |=>
    phase_q == ($past(phase_q) == 4'h8 ? 4'h1 : $past(phase_q) << 1)) else $error("phase order");
  a_addr_first: assert property ($changed(prog_addr_q) |-> phase_q == 4'h1)
    else $error("address moved outside first phase");
  a_step_one: assert property (real_end ##0 plain |=> prog_addr_q == $past(inc))
    else $error("counter did not step by one");
  a_jump_dest: assert property (real_end ##0 jc |=> !exec_valid_q &&
    prog_addr_q == {$past(bank_pointer_bit5), $past(addr_field)}) else $error("branch target");
  a_skip_two: assert property (real_end ##0 (skip_taken && !jc && !rt && !pcl_write) |=>
    !exec_valid_q && prog_addr_q == $past(inc)) else $error("skip target");
  a_pcl_page: assert property (real_end ##0 (pcl_write && !jc && !rt) |=>
    !exec_valid_q && prog_addr_q == $past(pg)) else $error("low byte jump left page");
  a_dummy_len: assert property ($fell(exec_valid_q) && irq_pend_q == 6'h00 |->
    dummy_run ##1 exec_valid_q) else $error("dummy cycle length");
  a_ack_vec: assert property (irq_ack_q != 6'h00 |->
    $onehot(irq_ack_q) && phase_q == 4'h1 && prog_addr_q == vec) else $error("vector");
  a_ack_full: assert property (irq_ack_q != 6'h00 |-> !$past(stack_full_q))
    else $error("acknowledge with full stack");
  a_reset_vals: assert property (disable iff (1'b0) sys_rst |=>
    prog_addr_q == 14'h0000 && phase_q == 4'h1 && !stack_full_q && irq_ack_q == 6'h00)
    else $error("reset state");
endmodule // pcss_seq_chk

bind pcss_seq pcss_seq_chk u_chk (.clk_sys, .sys_rst, .addr_field, .bank_pointer_bit5,
  .unconditional_jump, .call_op, .subroutine_exit, .isr_exit, .skip_taken, .pcl_write,
  .pcl_wdata, .irq_req, .phase_q, .prog_addr_q, .exec_valid_q, .irq_pend_q, .irq_ack_q,
  .stack_full_q);

//--- bench/pcss_mem_model.sv
/* Far side of the sequencer: program memory and interrupt sources.
   Assumes fetches and request pulses on clk_sys. */
`timescale 1ns/1ns
module pcss_mem_model (
  input  wire        clk_sys,
  input  wire [13:0] prog_addr_q,
  output wire [15:0] prog_data,
  output reg  [5:0]  irq_req
);
  // Each word carries its own address, so a wrong fetch shows at once
  assign prog_data = {2'h2, prog_addr_q};
  initial irq_req = 6'h00;
  task fire(input integer i);
    begin
      @(posedge clk_sys);
      #1 irq_req = 6'h01 << i;
      @(posedge clk_sys);
      #1 irq_req = 6'h00;
    end
  endtask
endmodule // pcss_mem_model

//--- bench/pc_stack_sequencer_test.sv
/* Testbench of pcss_seq: drives decoded controls in the fourth phase of
   real cycles, checks fetch address, executed word, dummy cycles, stack and
   vectors. Assumes pcss_mem_model answers fetches and raises requests. */
`timescale 1ns/1ns
module pc_stack_sequencer_test;
  reg         clk_sys = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [5:0]  ctl = 6'h00;
  reg  [7:0]  pcl_wdata = 8'h00;
  reg  [12:0] addr_field = 13'h0000;
  reg         bank_pointer_bit5 = 1'b0;
  reg         int_enable = 1'b0;
  reg  [13:0] pc0, sv;
  reg  [5:0]  ack0;
  integer     failures = 0, num_checks = 0, i;
  wire [15:0] prog_data, exec_instr_q;
  wire [5:0]  irq_req, irq_pend_q, irq_ack_q;
  wire [13:0] prog_addr_q;
  wire [7:0]  program_counter_low_q;
  wire [3:0]  phase_q;
  wire        exec_valid_q, stack_full_q;

  pcss_seq dut (.clk_sys, .sys_rst, .prog_data, .unconditional_jump(ctl[5]), .call_op(ctl[4]),
    .subroutine_exit(ctl[3]), .isr_exit(ctl[2]), .skip_taken(ctl[1]), .pcl_write(ctl[0]),
    .pcl_wdata, .addr_field, .bank_pointer_bit5, .int_enable, .irq_req, .phase_q, .prog_addr_q,
    .program_counter_low_q, .exec_instr_q, .exec_valid_q, .irq_pend_q, .irq_ack_q, .stack_full_q);
  pcss_mem_model mem (.clk_sys, .prog_addr_q, .prog_data, .irq_req);
  always #25 clk_sys = ~clk_sys;
  // ****************
  // Tasks
  // ****************
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Controls are held through the fourth phase of a real cycle only
  task step(input [5:0] c);
    integer n;
    begin
      n = 0;
      do begin
        @(posedge clk_sys);
        #1 n = n + 1;
      end while (!(phase_q === 4'h8 && exec_valid_q === 1'b1) && n < 40);
      if (!(phase_q === 4'h8 && exec_valid_q === 1'b1)) begin
        failures = failures + 1;
        $display("Error at %0t: no real fourth phase", $time);
      end
      pc0 = prog_addr_q;
      ctl = c;
      @(posedge clk_sys);
      #1 ctl = 6'h00;
      ack0 = irq_ack_q;
    end
  endtask
  task redir(input [5:0] c, input [13:0] rt);
    reg [13:0] t;
    begin
      step(c);
      t = c[5:4] != 2'h0 ? {bank_pointer_bit5, addr_field} :
          c[1] ? {pc0[13], pc0[12:0] + 13'h0001} : c[0] ? {pc0[13:8], pcl_wdata} : rt;
      chk(prog_addr_q, t);
      chk(program_counter_low_q, t[7:0]);
      chk(exec_valid_q, 1'b0);
      repeat (4) @(posedge clk_sys);
      #1 chk(exec_valid_q, 1'b1);
      chk(exec_instr_q, {2'h2, t});
      chk(prog_addr_q, {t[13], t[12:0] + 13'h0001});
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d, failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // ****************
  // Scenarios
  // ****************
  task t_plain;
    begin
      chk(prog_addr_q, 14'h0000);
      chk(phase_q, 4'h1);
      for (i = 0; i < 3; i = i + 1) begin
        step(6'h00);
        chk(prog_addr_q, pc0 + 14'h0001);
        chk(exec_instr_q, {2'h2, pc0});
      end
    end
  endtask
  // Page and bank edges: low byte near 0xff, counter field at its top
  task t_branch;
    begin
      bank_pointer_bit5 = 1'b1;
      addr_field = 13'h1234;
      redir(6'h20, 14'h0000);
      pcl_wdata = 8'hfe;
      redir(6'h01, 14'h0000);
      redir(6'h02, 14'h0000);
      addr_field = 13'h1ffe;
      redir(6'h20, 14'h0000);
      redir(6'h02, 14'h0000);
    end
  endtask
  task t_vectors;
    begin
      mem.fire(0);
      step(6'h00);
      chk(ack0, 6'h00);
      chk(irq_pend_q, 6'h01);
      int_enable = 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
        if (i > 0)
          mem.fire(i);
        redir(6'h00, {9'h000, i[2:0] + 3'h1, 2'h0});
        chk(ack0, 6'h01 << i);
        sv = pc0;
        redir(6'h04, sv);
      end
    end
  endtask
  task t_stack;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        addr_field = {5'h01, i[7:0]};
        redir(6'h10, 14'h0000);
      end
      sv = pc0;
      chk(stack_full_q, 1'b1);
      mem.fire(1);
      step(6'h00);
      chk(ack0, 6'h00);
      // Enable held off over the return: a request may be taken in a dummy cycle
      int_enable = 1'b0;
      redir(6'h08, sv);
      int_enable = 1'b1;
      redir(6'h00, 14'h0008);
      chk(ack0, 6'h02);
      chk(stack_full_q, 1'b1);
      addr_field = 13'h0777;
      redir(6'h10, 14'h0000);
      chk(stack_full_q, 1'b1);
      sys_rst = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1 chk(stack_full_q, 1'b0);
      sys_rst = 1'b0;
      step(6'h00);
      chk(prog_addr_q, 14'h0002);
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    t_plain;
    t_branch;
    t_vectors;
    t_stack;
    finish_test;
  end
  // Whole run needs well under a thousand cycles; six thousand means a hang
  initial begin
    #300000;
    failures = failures + 1;
    finish_test;
  end
endmodule // pc_stack_sequencer_test
